// File: rtl/ddrsw_pkg.sv
/*
  ddrsw_pkg: shared widths, lane layout and burst constants for the
  double-data-rate write port and shared address capture.
  Assumes the wide (36-bit data, 19-bit address) configuration.
*/
package ddrsw_pkg;
  localparam int DDRSW_DATA_W = 36;
  localparam int DDRSW_ADDR_W = 19;
  localparam int DDRSW_LANES = 4;
  localparam int DDRSW_LANE_W = 9;
  localparam int DDRSW_LANE0_LSB = 0;
  localparam int DDRSW_LANE1_LSB = 9;
  localparam int DDRSW_LANE2_LSB = 18;
  localparam int DDRSW_LANE3_LSB = 27;
  localparam int DDRSW_BURST_LEN = 2;
  localparam int DDRSW_DEPTH = 16;
  localparam int DDRSW_IDX_W = 4;
  localparam int DDRSW_FIFO_DEPTH = 2;
  localparam logic [3:0] DDRSW_BWS_IDLE = 4'hF;
  localparam logic [35:0] DDRSW_DATA_RST = 36'h0_0000_0000;
  localparam logic [18:0] DDRSW_ADDR_RST = 19'h0_0000;

  typedef logic [DDRSW_DATA_W-1:0] ddrsw_word_t;
  typedef logic [DDRSW_ADDR_W-1:0] ddrsw_addr_t;
  typedef logic [DDRSW_LANES-1:0] ddrsw_bws_t;

  // write request the controller takes from its user
  typedef struct packed {
    ddrsw_addr_t addr;
    ddrsw_word_t word0;
    ddrsw_bws_t bws0_n;
    ddrsw_word_t word1;
    ddrsw_bws_t bws1_n;
  } ddrsw_wreq_t;

  // merge enabled lanes of new into old
  function automatic ddrsw_word_t ddrsw_merge(ddrsw_word_t old_w, ddrsw_word_t new_w,
                                              ddrsw_bws_t bws_n);
    ddrsw_word_t r;
    r = old_w;
    for (int i = 0; i < DDRSW_LANES; i++) begin
      if (!bws_n[i]) begin
        r[i*DDRSW_LANE_W +: DDRSW_LANE_W] = new_w[i*DDRSW_LANE_W +: DDRSW_LANE_W];
      end
    end
    return r;
  endfunction
endpackage

// File: rtl/ddrsw_if.sv
/*
  ddrsw_if: the pin group between memory controller and device.
  Half-cycle phase is carried by kb_phase: low for the true clock edge,
  high for the complement edge; both ends run on one clk at twice rate.
*/
interface ddrsw_if;
  import ddrsw_pkg::*;
  logic kb_phase;
  logic write_port_select_n;
  logic read_port_select_n;
  ddrsw_bws_t byte_lane_write_select_n;
  ddrsw_word_t wdata;
  ddrsw_addr_t addr;

  modport ctrl (
    output kb_phase, write_port_select_n, read_port_select_n,
    output byte_lane_write_select_n, wdata, addr
  );
  modport dev (
    input kb_phase, write_port_select_n, read_port_select_n,
    input byte_lane_write_select_n, wdata, addr
  );
endinterface

// File: rtl/ddrsw_ctrl.sv
/*
  ddrsw_ctrl: controller end. Takes write and read requests from a user,
  buffers writes in a two-entry queue and drives the multiplexed pins.
  Each clk is one half of the input clock; phase 0 is the true edge.
*/
module ddrsw_ctrl
  import ddrsw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // user write request
  input wire logic wr_valid,
  output logic wr_ready,
  input wire ddrsw_pkg::ddrsw_wreq_t wr_req,
  // user read request
  input wire logic rd_valid,
  output logic rd_ready,
  input wire ddrsw_pkg::ddrsw_addr_t rd_addr,
  // pins
  ddrsw_if.ctrl pins
);
  import ddrsw_pkg::*;

  ddrsw_wreq_t q_ff [DDRSW_FIFO_DEPTH];
  logic [1:0] cnt_ff;
  logic wp_ff;
  logic rp_ff;
  logic phase_ff;
  ddrsw_wreq_t cur_ff;
  logic wr_ready_ff;
  logic rd_ready_ff;
  logic wps_n_ff;
  logic rps_n_ff;
  ddrsw_bws_t bws_ff;
  ddrsw_word_t d_ff;
  ddrsw_addr_t a_ff;

  // queue control; pins are set up one half ahead, so a launch or read
  // decided while phase_ff is high shows on the pins in a true half
  wire push = wr_valid && wr_ready_ff;
  wire launch = phase_ff && (cnt_ff != 2'd0);
  wire rd_go = phase_ff && rd_valid && rd_ready_ff;
  wire [1:0] nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, launch};
  wire wp_push = push ? ~wp_ff : wp_ff;
  wire rp_pop = launch ? ~rp_ff : rp_ff;

  assign wr_ready = wr_ready_ff;
  assign rd_ready = rd_ready_ff;
  assign pins.kb_phase = phase_ff;
  assign pins.write_port_select_n = wps_n_ff;
  assign pins.read_port_select_n = rps_n_ff;
  assign pins.byte_lane_write_select_n = bws_ff;
  assign pins.wdata = d_ff;
  assign pins.addr = a_ff;

  // buffer storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      q_ff[wp_ff] <= wr_req;
    end
  end

  // pointers, phase and handshake flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 2'd0;
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      phase_ff <= 1'b0;
      wr_ready_ff <= 1'b0;
      rd_ready_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      wp_ff <= wp_push;
      rp_ff <= rp_pop;
      phase_ff <= ~phase_ff;
      wr_ready_ff <= nxt_cnt < 2'(DDRSW_FIFO_DEPTH);
      rd_ready_ff <= !phase_ff; // stands in the half that sets up a true half
    end
  end

  // pin drive: word0/bws0 and read addr on true edge, word1/bws1 and write
  // addr on complement edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wps_n_ff <= 1'b1;
      rps_n_ff <= 1'b1;
      bws_ff <= DDRSW_BWS_IDLE;
      d_ff <= DDRSW_DATA_RST;
      a_ff <= DDRSW_ADDR_RST;
      cur_ff <= '0;
    end else if (phase_ff) begin
      wps_n_ff <= !launch;
      rps_n_ff <= !rd_go;
      bws_ff <= launch ? q_ff[rp_ff].bws0_n : DDRSW_BWS_IDLE;
      d_ff <= launch ? q_ff[rp_ff].word0 : DDRSW_DATA_RST;
      a_ff <= rd_go ? rd_addr : DDRSW_ADDR_RST;
      cur_ff <= launch ? q_ff[rp_ff] : cur_ff;
    end else begin
      wps_n_ff <= 1'b1;
      rps_n_ff <= 1'b1;
      bws_ff <= wps_n_ff ? DDRSW_BWS_IDLE : cur_ff.bws1_n;
      d_ff <= wps_n_ff ? DDRSW_DATA_RST : cur_ff.word1;
      a_ff <= wps_n_ff ? DDRSW_ADDR_RST : cur_ff.addr;
    end
  end
endmodule

// File: rtl/ddrsw_dev.sv
/*
  ddrsw_dev: device end. Samples the pins on each half-cycle, captures
  read and write addresses from the shared bus and performs byte-masked
  two-word writes into a small model array.
  Assumes kb_phase toggles every clk, low marking the true clock edge.
  Assumes the controller opens a write at most once per two halves and
  holds every pin for its whole half; nothing here resynchronises them.
  The array is a small model: only the low address bits pick a row, so
  higher addresses alias onto it.
  A read issued in the same true half as a commit to its row returns the
  row as written by that commit; the array updates before the first beat is read.
*/

module ddrsw_dev (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  ddrsw_if.dev pins,
  // write completion towards the array owner
  output logic wr_done,
  output ddrsw_pkg::ddrsw_addr_t wr_addr,
  // read start with captured address and burst beat
  output logic rd_start,
  output ddrsw_pkg::ddrsw_addr_t rd_addr,
  output logic rd_beat,
  output ddrsw_pkg::ddrsw_word_t rd_word
);
  import ddrsw_pkg::*;

  typedef enum logic [2:0] {
    DDRSW_W_IDLE = 3'b001,
    DDRSW_W_BEAT1 = 3'b010,
    DDRSW_W_COMMIT = 3'b100
  } ddrsw_wst_t;

  ddrsw_wst_t wst_ff, nxt_wst;
  ddrsw_word_t mem_ff [DDRSW_DEPTH][DDRSW_BURST_LEN];
  ddrsw_word_t w0_ff;
  ddrsw_bws_t b0_ff;
  ddrsw_word_t w1_ff;
  ddrsw_bws_t b1_ff;
  ddrsw_addr_t wa_ff;
  logic wr_done_ff;
  ddrsw_addr_t wr_addr_ff;
  logic rd_start_ff;
  ddrsw_addr_t rd_addr_ff;
  logic rd_beat_ff;
  logic rd_second_ff;
  ddrsw_word_t rd_word_ff;
  ddrsw_addr_t rburst_addr_ff;

  // row of the model array that an address picks; the upper bits alias
  function automatic logic [DDRSW_IDX_W-1:0] row_of(ddrsw_addr_t a);
    return a[DDRSW_IDX_W-1:0];
  endfunction

  // sequencer state decode, shared by capture, commit and completion
  wire wr_idle = wst_ff == DDRSW_W_IDLE;
  wire wr_beat1 = wst_ff == DDRSW_W_BEAT1;
  wire wr_commit = wst_ff == DDRSW_W_COMMIT;

  // edge decode: starts only on true phase
  // a write may open in the commit half, so one write per two halves
  // keeps up; the commit still reads the burst registers before reload
  wire true_edge = !pins.kb_phase;
  wire wr_free = wr_idle || wr_commit;
  wire wr_take = true_edge && !pins.write_port_select_n && wr_free;
  wire rd_take = true_edge && !pins.read_port_select_n;
  wire [DDRSW_IDX_W-1:0] widx = row_of(wa_ff);
  wire [DDRSW_IDX_W-1:0] ridx = row_of(rburst_addr_ff);

  // read next values; the address holds while the port is deselected
  wire [DDRSW_ADDR_W-1:0] nxt_rd_addr = rd_take ? pins.addr : rd_addr_ff;
  wire [DDRSW_DATA_W-1:0] beat0_word = mem_ff[ridx][0];
  wire [DDRSW_DATA_W-1:0] beat1_word = mem_ff[ridx][1];
  wire [DDRSW_DATA_W-1:0] held_word = rd_second_ff ? beat1_word : rd_word_ff;
  wire [DDRSW_DATA_W-1:0] nxt_rd_word = rd_start_ff ? beat0_word : held_word;

  // write sequencer: word0 on true edge, word1 + address on complement
  always_comb begin
    nxt_wst = wst_ff;
    unique case (wst_ff)
      DDRSW_W_IDLE: nxt_wst = wr_take ? DDRSW_W_BEAT1 : DDRSW_W_IDLE;
      DDRSW_W_BEAT1: nxt_wst = DDRSW_W_COMMIT;
      DDRSW_W_COMMIT: nxt_wst = wr_take ? DDRSW_W_BEAT1 : DDRSW_W_IDLE;
      default: nxt_wst = DDRSW_W_IDLE;
    endcase
  end

  // sequencer state; back to idle on reset so no burst is half taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_ff <= DDRSW_W_IDLE;
    end else begin
      wst_ff <= nxt_wst;
    end
  end

  // first word and its lane selects, on the edge that opens the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w0_ff <= DDRSW_DATA_RST;
      b0_ff <= DDRSW_BWS_IDLE;
    end else if (wr_take) begin
      w0_ff <= pins.wdata;
      b0_ff <= pins.byte_lane_write_select_n;
    end
  end

  // second word and its lane selects on the following complement half
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w1_ff <= DDRSW_DATA_RST;
      b1_ff <= DDRSW_BWS_IDLE;
    end else if (wr_beat1) begin
      w1_ff <= pins.wdata;
      b1_ff <= pins.byte_lane_write_select_n;
    end
  end

  // write address on the complement half only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wa_ff <= DDRSW_ADDR_RST;
    end else if (wr_beat1) begin
      wa_ff <= pins.addr;
    end
  end

  // array update with per-lane merge; deselected lanes keep old bits
  always_ff @(posedge clk) begin
    if (wr_commit) begin
      mem_ff[widx][0] <= ddrsw_merge(mem_ff[widx][0], w0_ff, b0_ff);
      mem_ff[widx][1] <= ddrsw_merge(mem_ff[widx][1], w1_ff, b1_ff);
    end
  end

  // write completion strobe, one cycle per committed burst
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_done_ff <= 1'b0;
    end else begin
      wr_done_ff <= wr_commit;
    end
  end

  // completed write address, held until the next commit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_addr_ff <= DDRSW_ADDR_RST;
    end else if (wr_commit) begin
      wr_addr_ff <= wa_ff;
    end
  end

  // read side runs independently of the write sequencer
  // start strobe, then two beats per read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_start_ff <= 1'b0;
      rd_second_ff <= 1'b0;
      rd_beat_ff <= 1'b0;
    end else begin
      rd_start_ff <= rd_take;
      rd_second_ff <= rd_start_ff;
      rd_beat_ff <= rd_start_ff || rd_second_ff;
    end
  end

  // read address on true edge only when selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_ff <= DDRSW_ADDR_RST;
      rburst_addr_ff <= DDRSW_ADDR_RST;
    end else begin
      rd_addr_ff <= nxt_rd_addr;
      rburst_addr_ff <= nxt_rd_addr;
    end
  end

  // burst word register; holds its last beat between reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_word_ff <= DDRSW_DATA_RST;
    end else begin
      rd_word_ff <= nxt_rd_word;
    end
  end

  // outputs straight from their registers
  assign wr_done = wr_done_ff;
  assign wr_addr = wr_addr_ff;
  assign rd_start = rd_start_ff;
  assign rd_addr = rd_addr_ff;
  assign rd_beat = rd_beat_ff;
  assign rd_word = rd_word_ff;
endmodule

// File: tb/ddrsw_assertions.sv
/*
  ddrsw_assertions: pin timing and completion checks for the port pair.
  Assumes one clk, async low rst_n and the wide widths of ddrsw_pkg.
*/
module ddrsw_assertions
  import ddrsw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic kb_phase,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire ddrsw_pkg::ddrsw_bws_t byte_lane_write_select_n,
  input wire ddrsw_pkg::ddrsw_word_t wdata,
  input wire ddrsw_pkg::ddrsw_addr_t addr,
  // device side results
  input wire logic wr_done,
  input wire ddrsw_pkg::ddrsw_addr_t wr_addr,
  input wire logic rd_start,
  input wire ddrsw_pkg::ddrsw_addr_t rd_addr,
  input wire logic rd_beat
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a write opens on the true half and its select drops on the next half
  sequence s_wr_start;
    !kb_phase && !write_port_select_n;
  endsequence
  sequence s_wr_second;
    kb_phase && write_port_select_n;
  endsequence
  a_phase_alternates: assert property (1 |=> kb_phase != $past(kb_phase))
    else $error("half-cycle phase did not alternate");
  a_wsel_true_half: assert property (!write_port_select_n |-> !kb_phase)
    else $error("write select on complement half");
  a_rsel_true_half: assert property (!read_port_select_n |-> !kb_phase)
    else $error("read select on complement half");
  a_write_burst_pair: assert property (s_wr_start |=> s_wr_second)
    else $error("write burst second half malformed");
  a_write_done_lat: assert property (s_wr_start ##1 1 |-> ##2 wr_done && wr_addr == $past(addr, 2))
    else $error("write done or write address wrong");
  a_done_has_cause: assert property (wr_done |-> $past(write_port_select_n, 3) == 1'b0)
    else $error("write done without a selected write");
  a_read_addr_cap: assert property (!read_port_select_n |=> rd_start && rd_addr == $past(addr))
    else $error("read address not captured on true half");
  a_read_start_cause: assert property (rd_start |-> $past(read_port_select_n) == 1'b0)
    else $error("read start while read port deselected");
  a_read_two_beats: assert property (rd_start |=> rd_beat [*2])
    else $error("read burst not two beats");
  a_lanes_idle_off: assert property (!kb_phase && write_port_select_n |->
      byte_lane_write_select_n == DDRSW_BWS_IDLE && wdata == DDRSW_DATA_RST)
    else $error("lanes or data not idle while write port deselected");
endmodule

// File: tb/tb.sv
/*
  tb: drives the controller user side, checks device results against a
  lane-merge model of the 16-entry array. Assumes ctrl and dev face each
  other through ddrsw_if on one clk.
*/
module tb import ddrsw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, wr_valid, wr_ready, rd_valid, rd_ready, stalled;
  logic wr_done, rd_start, rd_beat;
  ddrsw_wreq_t wr_req;
  ddrsw_addr_t rd_addr_in, wr_addr, rd_addr;
  ddrsw_word_t rd_word;
  ddrsw_word_t mem [16][2];
  ddrsw_word_t exp_q [$];
  int num_errors, cmp_count, wr_cnt, done_cnt, seed;
  ddrsw_if pins ();
  ddrsw_ctrl ddrsw_ctrl_inst (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_req(wr_req), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_addr(rd_addr_in), .pins(pins));
  ddrsw_dev ddrsw_dev_inst (.clk(clk), .rst_n(rst_n), .pins(pins), .wr_done(wr_done),
    .wr_addr(wr_addr), .rd_start(rd_start), .rd_addr(rd_addr), .rd_beat(rd_beat),
    .rd_word(rd_word));
  ddrsw_assertions ddrsw_assertions_inst (.clk(clk), .rst_n(rst_n),
    .kb_phase(pins.kb_phase), .write_port_select_n(pins.write_port_select_n),
    .read_port_select_n(pins.read_port_select_n), .wdata(pins.wdata), .addr(pins.addr),
    .byte_lane_write_select_n(pins.byte_lane_write_select_n), .wr_done(wr_done),
    .wr_addr(wr_addr), .rd_start(rd_start), .rd_addr(rd_addr), .rd_beat(rd_beat));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // mask built per lane, so a lane off by one bit shows up
  function automatic ddrsw_word_t exp_merge(ddrsw_word_t o, ddrsw_word_t n, ddrsw_bws_t s);
    ddrsw_word_t m;
    m = '0;
    for (int i = 0; i < DDRSW_LANES; i++) begin
      if (s[i] == 1'b0) m = m | (36'h0_0000_01FF << (i * DDRSW_LANE_W));
    end
    return (o & ~m) | (n & m);
  endfunction
  function automatic ddrsw_word_t rnd_w();
    return {4'($random(seed)), 32'($random(seed))};
  endfunction
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // caller holds wr_valid, so pushes can come every cycle and fill the queue
  task automatic do_wr(input ddrsw_addr_t a, input ddrsw_bws_t b0, input ddrsw_bws_t b1);
    ddrsw_word_t w0, w1;
    w0 = rnd_w();
    w1 = rnd_w();
    wr_req = '{a, w0, b0, w1, b1};
    @(posedge clk);
    while (wr_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    mem[a[3:0]][0] = exp_merge(mem[a[3:0]][0], w0, b0);
    mem[a[3:0]][1] = exp_merge(mem[a[3:0]][1], w1, b1);
    wr_cnt++;
  endtask
  task automatic do_rd(input ddrsw_addr_t a);
    rd_addr_in = a;
    @(posedge clk);
    while (rd_ready !== 1'b1) @(posedge clk);
    exp_q.push_back(mem[a[3:0]][0]);
    exp_q.push_back(mem[a[3:0]][1]);
    @(negedge clk);
  endtask
  // queued writes must land before the array is read back
  task automatic read_all(input string name);
    repeat (40) if (done_cnt != wr_cnt) @(negedge clk);
    check(36'(done_cnt), 36'(wr_cnt));
    rd_valid = 1'b1;
    for (int i = 0; i < 16; i++) do_rd(ddrsw_addr_t'(i + 16 * ($random(seed) & 7)));
    rd_valid = 1'b0;
    while (exp_q.size() > 0) @(negedge clk);
    $display("%s done", name);
  endtask
  // beats come out in burst order, word 0 first
  always @(negedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b0) stalled = 1'b1;
    if (wr_done === 1'b1) done_cnt++;
    if (rst_n && rd_beat === 1'b1) begin
      check(rd_word, (exp_q.size() > 0) ? exp_q.pop_front() : 36'hx);
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    ddrsw_bws_t corner [6];
    corner = '{4'hF, 4'hE, 4'h7, 4'h5, 4'hA, 4'hB};
    seed = 32'h440b;
    {wr_valid, rd_valid, stalled, rst_n} = 4'h0;
    wr_req = '0;
    rd_addr_in = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    wr_valid = 1'b1;
    for (int i = 0; i < 16; i++) do_wr(ddrsw_addr_t'(i), 4'h0, 4'h0);
    wr_valid = 1'b0;
    read_all("full writes");
    check(stalled, 1'b1);
    wr_valid = 1'b1;
    for (int i = 0; i < 30; i++) begin
      do_wr(ddrsw_addr_t'($random(seed)), (i < 6) ? corner[i] : 4'($random(seed)),
            (i < 6) ? corner[5 - i] : 4'($random(seed)));
    end
    wr_valid = 1'b0;
    read_all("masked writes");
    {wr_valid, rd_valid} = 2'h3;
    // two reads back to back, so one shares its true half with the write
    fork
      do_wr(ddrsw_addr_t'(3), 4'h6, 4'h9);
      begin
        do_rd(ddrsw_addr_t'(12));
        do_rd(ddrsw_addr_t'(13));
      end
    join
    {wr_valid, rd_valid} = 2'h0;
    read_all("concurrent");
    report_and_stop();
  end
endmodule
